// ===== exec_core.sv
`timescale 1ns/1ps
// Functional notes
// - Add and add-with-carry take one word and one cycle in five forms and set all five flags.
// - One-place arithmetic shift right keeps sign, one cycle, updates carry, N, overflow, Z.
// - A multi-place arithmetic right shift by register or 5-bit literal takes one cycle and sets only N and Z.
// - Signed branches take one cycle when not taken, two when taken, and leave the flags alone.
// - Unsigned branches compare through carry, take one or two cycles and leave the flags alone.
// - Single-flag branches take one or two cycles, unconditional and computed branches two, and no branch alters flags.
// - Bit test and skip if clear takes one cycle, two or three on a skip, and alters no flag.
module exec_core (
   input wire logic clk,
   input wire logic rst,
   input wire logic op_valid,
   input wire exec_pkg::op_t op,
   input wire exec_pkg::form_t form,
   input wire exec_pkg::cond_t cond,
   input wire logic [exec_pkg::DATA_W-1:0] opnd_a,
   input wire logic [exec_pkg::DATA_W-1:0] opnd_b,
   input wire logic [exec_pkg::TEN_BIT_LITERAL_W-1:0] literal,
   input wire logic [exec_pkg::POS_W-1:0] four_bit_position,
   input wire logic [exec_pkg::DATA_W-1:0] branch_target,
   input wire logic next_is_two_word,
   output logic op_ready,
   output logic [exec_pkg::DATA_W-1:0] result_r,
   output exec_pkg::dest_t result_dest_r,
   output logic result_valid_r,
   output exec_pkg::flags_t flags_r,
   output logic pc_load_r,
   output logic [exec_pkg::DATA_W-1:0] pc_target_r,
   output logic skip_r
);
   import exec_pkg::*;

   alu_if alu ();

   alu_unit u_alu (
      .io(alu.unit)
   );

   state_t state_r;
   logic [1:0] stall_left_r;
   logic accept;
   logic [DATA_W-1:0] b_sel;
   logic taken;
   logic writes_result;
   logic [1:0] stall_nxt;
   dest_t dest_nxt;

   assign op_ready = (state_r == st_issue);
   assign accept = op_valid && op_ready;

   // Literal forms replace the second operand, zero extended
   always_comb begin
      case (form)
         form_ten_bit_literal: b_sel = {{(DATA_W-TEN_BIT_LITERAL_W){1'b0}}, literal};
         form_five_bit_literal: begin
            b_sel = {{(DATA_W-FIVE_BIT_LITERAL_W){1'b0}}, literal[FIVE_BIT_LITERAL_W-1:0]};
         end
         default: b_sel = opnd_b;
      endcase
   end

   assign alu.a = opnd_a;
   assign alu.b = b_sel;
   assign alu.count = (form == form_five_bit_literal) ? literal[COUNT_W-1:0]
                      : opnd_b[COUNT_W-1:0];
   assign alu.pos = (op == flag_to_bit_write_op || op == flag_to_bit_write_zero_op)
                    ? opnd_b[POS_W-1:0] : four_bit_position;
   assign alu.op = op;
   // Plain add must not pick up the live carry
   always_comb begin
      alu.fin = flags_r;
      if (op == add_op) begin
         alu.fin.c = 1'b0;
      end
   end

   // Branch condition evaluation from the current flags
   always_comb begin
      case (cond)
         cond_always: taken = 1'b1;
         cond_c: taken = flags_r.c;
         cond_nc: taken = !flags_r.c;
         cond_n: taken = flags_r.n;
         cond_nn: taken = !flags_r.n;
         cond_overflow: taken = flags_r.overflow;
         cond_no_overflow: taken = !flags_r.overflow;
         cond_z: taken = flags_r.z;
         cond_nz: taken = !flags_r.z;
         cond_ge: taken = !(flags_r.n ^ flags_r.overflow);
         cond_gt: taken = !flags_r.z && !(flags_r.n ^ flags_r.overflow);
         cond_le: taken = flags_r.z || (flags_r.n ^ flags_r.overflow);
         cond_lt: taken = flags_r.n ^ flags_r.overflow;
         cond_geu: taken = flags_r.c;
         cond_gtu: taken = flags_r.c && !flags_r.z;
         cond_leu: taken = !flags_r.c || flags_r.z;
         default: taken = 1'b0;
      endcase
   end

   always_comb begin
      case (op)
         add_op, add_with_carry_op, arith_shift_right_op, arith_shift_right_multi_op,
         bit_set_op, bit_clear_op, bit_toggle_op, flag_to_bit_write_op,
         flag_to_bit_write_zero_op: writes_result = 1'b1;
         default: writes_result = 1'b0;
      endcase
      case (form)
         form_file: dest_nxt = dest_file;
         form_file_to_working: dest_nxt = dest_working;
         default: dest_nxt = dest_register;
      endcase
      case (op)
         branch_op: stall_nxt = taken ? STALL_TAKEN : STALL_NONE;
         computed_branch_op: stall_nxt = STALL_TAKEN;
         bit_test_skip_clear_op: begin
            if (alu.bit_val) begin
               stall_nxt = STALL_NONE;
            end else begin
               stall_nxt = next_is_two_word ? STALL_SKIP_TWO : STALL_SKIP_ONE;
            end
         end
         default: stall_nxt = STALL_NONE;
      endcase
   end

   // Issue/stall sequencing: a redirect or skip holds off the next issue
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= st_issue;
         stall_left_r <= STALL_NONE;
      end else begin
         case (state_r)
            st_issue: begin
               if (accept && stall_nxt != STALL_NONE) begin
                  state_r <= st_stall;
                  stall_left_r <= stall_nxt;
               end
            end
            st_stall: begin
               stall_left_r <= stall_left_r - 2'h1;
               if (stall_left_r == 2'h1) begin
                  state_r <= st_issue;
               end
            end
            default: begin
               state_r <= st_issue;
               stall_left_r <= STALL_NONE;
            end
         endcase
      end
   end

   // Flags move only for arithmetic; the ALU passes them through otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         flags_r <= FLAGS_RESET;
      end else if (accept) begin
         flags_r <= alu.fout;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         result_r <= RESULT_RESET;
         result_dest_r <= dest_file;
         result_valid_r <= 1'b0;
      end else begin
         result_valid_r <= accept && writes_result;
         if (accept && writes_result) begin
            result_r <= alu.res;
            result_dest_r <= dest_nxt;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pc_load_r <= 1'b0;
         pc_target_r <= RESULT_RESET;
         skip_r <= 1'b0;
      end else begin
         pc_load_r <= accept && (op == computed_branch_op || (op == branch_op && taken));
         skip_r <= accept && (op == bit_test_skip_clear_op) && !alu.bit_val;
         if (accept && (op == computed_branch_op || op == branch_op)) begin
            pc_target_r <= branch_target;
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence one_stall_s;
      !op_ready ##1 op_ready;
   endsequence

   sequence two_stall_s;
      !op_ready ##1 !op_ready ##1 op_ready;
   endsequence

   chk_add_zero_flag: assert property (
      accept && (op == add_op || op == add_with_carry_op) && alu.res == '0
      |=> flags_r.z && result_valid_r && result_r == '0 && op_ready)
      else $error("add result zero without Z or valid");

   chk_shift_sign_keep: assert property (
      accept && op == arith_shift_right_op
      |=> result_r[DATA_W-1] == $past(opnd_a[DATA_W-1]) && flags_r.c == $past(opnd_a[0])
          && !flags_r.overflow)
      else $error("single shift lost sign or carry");

   chk_multi_carry_hold: assert property (
      accept && op == arith_shift_right_multi_op
      |=> flags_r.c == $past(flags_r.c) && flags_r.overflow == $past(flags_r.overflow) && op_ready)
      else $error("multi shift touched carry or overflow");

   chk_signed_taken_two: assert property (
      accept && op == branch_op && cond == cond_lt && (flags_r.n ^ flags_r.overflow)
      |=> pc_load_r ##0 one_stall_s)
      else $error("taken signed branch not two cycles");

   chk_unsigned_carry: assert property (
      accept && op == branch_op && cond == cond_geu |=> pc_load_r == $past(flags_r.c))
      else $error("unsigned branch ignored carry");

   chk_not_taken_one: assert property (
      accept && op == branch_op && !taken |=> op_ready && !pc_load_r)
      else $error("not taken branch stalled");

   chk_branch_flags_kept: assert property (
      accept && (op == branch_op || op == computed_branch_op) |=> $stable(flags_r))
      else $error("branch altered flags");

   chk_skip_three_cycles: assert property (
      accept && op == bit_test_skip_clear_op && !alu.bit_val && next_is_two_word
      |=> skip_r ##0 two_stall_s)
      else $error("two word skip not three cycles");

   chk_bitop_one_cycle: assert property (
      accept && (op == bit_set_op || op == bit_clear_op || op == bit_toggle_op
                 || op == flag_to_bit_write_op || op == flag_to_bit_write_zero_op)
      |=> $stable(flags_r) && op_ready && result_valid_r)
      else $error("bit op changed flags or stalled");

endmodule : exec_core

// ===== exec_pkg.sv
package exec_pkg;

   localparam int DATA_W = 16;
   localparam int COUNT_W = 5;
   localparam int POS_W = 4;
   localparam int TEN_BIT_LITERAL_W = 10;
   localparam int FIVE_BIT_LITERAL_W = 5;
   localparam int NIBBLE_TOP = 3;

   // Extra stall cycles beyond the single issue cycle
   localparam logic [1:0] STALL_NONE = 2'h0;
   localparam logic [1:0] STALL_TAKEN = 2'h1;
   localparam logic [1:0] STALL_SKIP_ONE = 2'h1;
   localparam logic [1:0] STALL_SKIP_TWO = 2'h2;

   localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;

   typedef struct packed {
      logic c;
      logic digit_carry;
      logic n;
      logic overflow;
      logic z;
   } flags_t;

   localparam flags_t FLAGS_RESET = '{c: 1'b0, digit_carry: 1'b0, n: 1'b0, overflow: 1'b0,
      z: 1'b0};

   typedef enum logic [3:0] {
      nop_op = 4'h0,
      add_op = 4'h1,
      add_with_carry_op = 4'h2,
      arith_shift_right_op = 4'h3,
      arith_shift_right_multi_op = 4'h4,
      branch_op = 4'h5,
      computed_branch_op = 4'h6,
      bit_test_skip_clear_op = 4'h7,
      bit_set_op = 4'h8,
      bit_clear_op = 4'h9,
      bit_toggle_op = 4'ha,
      flag_to_bit_write_op = 4'hb,
      flag_to_bit_write_zero_op = 4'hc
   } op_t;

   typedef enum logic [2:0] {
      form_file = 3'h0,
      form_file_to_working = 3'h1,
      form_ten_bit_literal = 3'h2,
      form_three_reg = 3'h3,
      form_five_bit_literal = 3'h4
   } form_t;

   typedef enum logic [1:0] {
      dest_file = 2'h0,
      dest_working = 2'h1,
      dest_register = 2'h2
   } dest_t;

   typedef enum logic [3:0] {
      cond_always = 4'h0,
      cond_c = 4'h1, cond_nc = 4'h2,
      cond_n = 4'h3, cond_nn = 4'h4,
      cond_overflow = 4'h5, cond_no_overflow = 4'h6,
      cond_z = 4'h7, cond_nz = 4'h8,
      cond_ge = 4'h9, cond_gt = 4'ha, cond_le = 4'hb, cond_lt = 4'hc,
      cond_geu = 4'hd, cond_gtu = 4'he, cond_leu = 4'hf
   } cond_t;

   // Unsigned less-than is carry clear, the same test as cond_nc

   typedef enum logic [1:0] {
      st_issue = 2'b01,
      st_stall = 2'b10
   } state_t;

endpackage : exec_pkg

// ===== alu_if.sv
`timescale 1ns/1ps
interface alu_if;
   import exec_pkg::*;
   logic [DATA_W-1:0] a;
   logic [DATA_W-1:0] b;
   logic [COUNT_W-1:0] count;
   logic [POS_W-1:0] pos;
   flags_t fin;
   op_t op;
   logic [DATA_W-1:0] res;
   flags_t fout;
   logic bit_val;
   modport core (output a, b, count, pos, fin, op, input res, fout, bit_val);
   modport unit (input a, b, count, pos, fin, op, output res, fout, bit_val);
endinterface : alu_if

// ===== alu_unit.sv
`timescale 1ns/1ps
module alu_unit (
   alu_if.unit io
);
   import exec_pkg::*;

   function automatic logic is_zero(input logic [DATA_W-1:0] v);
      return v == '0;
   endfunction : is_zero

   logic [DATA_W:0] sum;
   logic [NIBBLE_TOP+1:0] low_sum;
   logic [DATA_W-1:0] one_hot;

   always_comb begin
      sum = {1'b0, io.a} + {1'b0, io.b} + {{DATA_W{1'b0}}, io.fin.c};
      low_sum = {1'b0, io.a[NIBBLE_TOP:0]} + {1'b0, io.b[NIBBLE_TOP:0]}
                + {{(NIBBLE_TOP+1){1'b0}}, io.fin.c};
      one_hot = 16'h0001 << io.pos;
      io.bit_val = io.a[io.pos];
      io.res = io.a;
      io.fout = io.fin;
      case (io.op)
         add_op, add_with_carry_op: begin
            io.res = sum[DATA_W-1:0];
            io.fout.c = sum[DATA_W];
            io.fout.digit_carry = low_sum[NIBBLE_TOP+1];
            io.fout.n = sum[DATA_W-1];
            io.fout.overflow = (io.a[DATA_W-1] == io.b[DATA_W-1])
                         && (sum[DATA_W-1] != io.a[DATA_W-1]);
            io.fout.z = is_zero(sum[DATA_W-1:0]);
         end
         arith_shift_right_op: begin
            io.res = {io.a[DATA_W-1], io.a[DATA_W-1:1]};
            io.fout.c = io.a[0];
            io.fout.n = io.a[DATA_W-1];
            io.fout.overflow = 1'b0;
            io.fout.z = is_zero({io.a[DATA_W-1], io.a[DATA_W-1:1]});
         end
         arith_shift_right_multi_op: begin
            io.res = $signed(io.a) >>> io.count;
            io.fout.n = io.a[DATA_W-1];
            io.fout.z = is_zero($signed(io.a) >>> io.count);
         end
         bit_set_op: io.res = io.a | one_hot;
         bit_clear_op: io.res = io.a & ~one_hot;
         bit_toggle_op: io.res = io.a ^ one_hot;
         flag_to_bit_write_op: io.res = io.fin.c ? (io.a | one_hot) : (io.a & ~one_hot);
         flag_to_bit_write_zero_op: io.res = io.fin.z ? (io.a | one_hot) : (io.a & ~one_hot);
         default: io.res = io.a;
      endcase
   end

endmodule : alu_unit

// ===== cpu_alu_branch_subset_tb_top.sv
`timescale 1ns/1ps
module cpu_alu_branch_subset_tb_top;
   import exec_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic op_valid = 1'b0;
   op_t op = nop_op;
   form_t form = form_file;
   cond_t cond = cond_always;
   logic [DATA_W-1:0] opnd_a = 16'h0000;
   logic [DATA_W-1:0] opnd_b = 16'h0000;
   logic [TEN_BIT_LITERAL_W-1:0] literal = 10'h000;
   logic [POS_W-1:0] four_bit_position = 4'h0;
   logic [DATA_W-1:0] branch_target = 16'h0000;
   logic next_is_two_word = 1'b0;
   logic op_ready;
   logic [DATA_W-1:0] result_r;
   dest_t result_dest_r;
   logic result_valid_r;
   flags_t flags_r;
   logic pc_load_r;
   logic [DATA_W-1:0] pc_target_r;
   logic skip_r;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   // Flags the bench expects the core to hold
   flags_t ef = FLAGS_RESET;

   always #20 clk = ~clk;

   exec_core u_exec_core (.clk(clk), .rst(rst), .op_valid(op_valid), .op(op), .form(form),
      .cond(cond), .opnd_a(opnd_a), .opnd_b(opnd_b), .literal(literal),
      .four_bit_position(four_bit_position), .branch_target(branch_target),
      .next_is_two_word(next_is_two_word), .op_ready(op_ready), .result_r(result_r),
      .result_dest_r(result_dest_r), .result_valid_r(result_valid_r), .flags_r(flags_r),
      .pc_load_r(pc_load_r), .pc_target_r(pc_target_r), .skip_r(skip_r));

   task automatic end_of_test();
      if (failures == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         failures++;
         end_of_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Called at a falling edge; op_valid stays up so the next call can follow back to back
   task automatic issue(op_t o, form_t f, cond_t c, logic [15:0] a, logic [15:0] b,
         logic [9:0] lit, logic [3:0] p, logic tw);
      op_valid = 1'b1;
      op = o;
      form = f;
      cond = c;
      opnd_a = a;
      opnd_b = b;
      literal = lit;
      four_bit_position = p;
      branch_target = ~a;
      next_is_two_word = tw;
      @(negedge clk);
   endtask : issue

   task automatic idle();
      op_valid = 1'b0;
      @(negedge clk);
   endtask : idle

   task automatic chk_res(logic [15:0] r, dest_t d);
      chk("result_valid", 1, result_valid_r);
      chk("result", r, result_r);
      chk("dest", d, result_dest_r);
      chk("flags", ef, flags_r);
   endtask : chk_res

   task automatic do_add(op_t o, form_t f, logic [15:0] a, logic [15:0] b, logic [9:0] lit,
         dest_t d);
      logic [15:0] bb;
      logic cin;
      logic [16:0] s;
      logic [4:0] lo;
      bb = (f == form_ten_bit_literal) ? {6'h00, lit}
           : (f == form_five_bit_literal) ? {11'h000, lit[4:0]} : b;
      cin = (o == add_with_carry_op) ? ef.c : 1'b0;
      s = a + bb + cin;
      lo = a[3:0] + bb[3:0] + cin;
      ef = '{c: s[16], digit_carry: lo[4], n: s[15],
         overflow: (a[15] == bb[15]) && (s[15] != a[15]), z: s[15:0] == 16'h0000};
      issue(o, f, cond_always, a, b, lit, 4'h0, 1'b0);
      chk_res(s[15:0], d);
   endtask : do_add

   task automatic test_add();
      do_add(add_op, form_file, 16'h7fff, 16'h0001, 10'h000, dest_file);
      do_add(add_op, form_file_to_working, 16'hffff, 16'h0001, 10'h000, dest_working);
      do_add(add_with_carry_op, form_ten_bit_literal, 16'h0001, 16'h0000, 10'h3ff,
         dest_register);
      do_add(add_with_carry_op, form_three_reg, 16'h8000, 16'h8000, 10'h000, dest_register);
      do_add(add_with_carry_op, form_five_bit_literal, 16'h000f, 16'h0000, 10'h3f1,
         dest_register);
      idle();
   endtask : test_add

   task automatic test_shift();
      logic [15:0] r;
      form_t fs[3] = '{form_file, form_file_to_working, form_three_reg};
      dest_t ds[3] = '{dest_file, dest_working, dest_register};
      logic [15:0] as[3] = '{16'h8003, 16'h0002, 16'h0001};
      foreach (fs[i]) begin
         r = {as[i][15], as[i][15:1]};
         ef = '{c: as[i][0], digit_carry: ef.digit_carry, n: r[15], overflow: 1'b0,
            z: r == 16'h0000};
         issue(arith_shift_right_op, fs[i], cond_always, as[i], 16'h0000, 10'h000, 4'h0, 1'b0);
         chk_res(r, ds[i]);
      end
      do_add(add_op, form_file, 16'h7fff, 16'h0001, 10'h000, dest_file);
      ef.n = 1'b1;
      ef.z = 1'b0;
      issue(arith_shift_right_multi_op, form_three_reg, cond_always, 16'h8000, 16'h00ff, 10'h000,
         4'h0, 1'b0);
      chk_res(16'hffff, dest_register);
      ef.n = 1'b0;
      ef.z = 1'b1;
      issue(arith_shift_right_multi_op, form_five_bit_literal, cond_always, 16'h0008, 16'h0000,
         10'h3e4, 4'h0, 1'b0);
      chk_res(16'h0000, dest_register);
      idle();
   endtask : test_shift

   function automatic logic taken(cond_t c, flags_t f);
      case (c)
         cond_always: return 1'b1;
         cond_c: return f.c;
         cond_nc: return !f.c;
         cond_n: return f.n;
         cond_nn: return !f.n;
         cond_overflow: return f.overflow;
         cond_no_overflow: return !f.overflow;
         cond_z: return f.z;
         cond_nz: return !f.z;
         cond_ge: return f.n == f.overflow;
         cond_gt: return !f.z && (f.n == f.overflow);
         cond_le: return f.z || (f.n != f.overflow);
         cond_lt: return f.n != f.overflow;
         cond_geu: return f.c;
         cond_gtu: return f.c && !f.z;
         default: return !f.c || f.z;
      endcase
   endfunction : taken

   task automatic do_br(op_t o, cond_t c, logic [15:0] a);
      logic tk;
      tk = (o == computed_branch_op) ? 1'b1 : taken(c, ef);
      issue(o, form_file, c, a, 16'h0000, 10'h000, 4'h0, 1'b0);
      chk("pc_load", tk, pc_load_r);
      chk("ready_in_branch", !tk, op_ready);
      chk("flags", ef, flags_r);
      if (tk) begin
         chk("pc_target", 16'(~a), pc_target_r);
      end
      idle();
      chk("ready_after", 1, op_ready);
   endtask : do_br

   task automatic test_branch();
      // The last value leaves negative set with overflow clear, so signed less-than is taken
      logic [15:0] va[4] = '{16'h7fff, 16'hffff, 16'h0001, 16'h8000};
      foreach (va[i]) begin
         do_add(add_op, form_three_reg, va[i], 16'h0001, 10'h000, dest_register);
         for (int c = 0; c < 16; c++) begin
            do_br(branch_op, cond_t'(c), 16'h1000 + 16'(c));
         end
         do_br(computed_branch_op, cond_nz, 16'h0abc);
      end
   endtask : test_branch

   task automatic do_skip_clear(logic [15:0] a, logic [3:0] p, logic tw);
      logic sk;
      sk = !a[p];
      issue(bit_test_skip_clear_op, form_file, cond_always, a, 16'h0000, 10'h000, p, tw);
      chk("skip", sk, skip_r);
      chk("ready_in_skip", !sk, op_ready);
      chk("flags", ef, flags_r);
      idle();
      chk("ready_after", !(sk && tw), op_ready);
      if (sk && tw) begin
         @(negedge clk);
         chk("ready_late", 1, op_ready);
      end
   endtask : do_skip_clear

   task automatic test_skip_clear();
      do_skip_clear(16'h7fff, 4'hf, 1'b0);
      do_skip_clear(16'hfffe, 4'h0, 1'b1);
      do_skip_clear(16'h8000, 4'hf, 1'b1);
   endtask : test_skip_clear

   task automatic test_bits();
      logic [15:0] a;
      a = 16'h5a5a;
      issue(bit_set_op, form_file, cond_always, a, 16'h0000, 10'h000, 4'h0, 1'b0);
      chk_res(a | 16'h0001, dest_file);
      issue(bit_clear_op, form_three_reg, cond_always, a, 16'h0000, 10'h000, 4'hf, 1'b0);
      chk_res(a, dest_register);
      issue(bit_toggle_op, form_file, cond_always, a, 16'h0000, 10'h000, 4'h3, 1'b0);
      chk_res(a ^ 16'h0008, dest_file);
      issue(flag_to_bit_write_op, form_three_reg, cond_always, a, 16'h00f0, 10'h000, 4'h0, 1'b0);
      chk_res(ef.c ? a | 16'h0001 : a & 16'hfffe, dest_register);
      issue(flag_to_bit_write_zero_op, form_three_reg, cond_always, a, 16'h0001, 10'h000, 4'h0,
         1'b0);
      chk_res(ef.z ? a | 16'h0002 : a & 16'hfffd, dest_register);
      idle();
   endtask : test_bits

   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk("ready_reset", 1, op_ready);
      chk("flags_reset", FLAGS_RESET, flags_r);
      chk("valid_reset", 0, result_valid_r);
      test_add();
      test_shift();
      test_branch();
      test_skip_clear();
      test_bits();
      end_of_test();
   end
endmodule : cpu_alu_branch_subset_tb_top
